/* inc/fms_pkg.sv */
// shared constants and types of the field motion statistics block
package fms_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_MOVE_THR   = 8'h04;
  localparam logic [7:0] OFS_VSMOOTH    = 8'h08;
  localparam logic [7:0] OFS_TEAR_MIN   = 8'h0C;
  localparam logic [7:0] OFS_TEAR_FLOOR = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_RESULT     = 8'h40;  // 11 words follow
  // control register bit positions
  localparam int CTRL_STREAM       = 0;
  localparam int CTRL_BOTTOM_FIRST = 1;
  localparam int CTRL_FIRST_FRAME  = 2;
  // reset values
  localparam logic [15:0] RST_MOVE_THR   = 16'h0100;
  localparam logic [9:0]  RST_VSMOOTH    = 10'h040;
  localparam logic [15:0] RST_TEAR_MIN   = 16'h0040;
  localparam logic [15:0] RST_TEAR_FLOOR = 16'h0004;
  // geometry and counts
  localparam int NUM_VAR     = 11;   // statistics per stream
  localparam int NUM_DIFF    = 5;    // summed squared differences
  localparam int BLK_PIX     = 32;   // even-row positions in 16x4 block
  localparam int BLK_COLS    = 16;
  localparam int DIV_SHIFT   = 4;    // block sum divided by 16
  localparam logic [3:0] LAST_VAR = 4'hA;
  localparam logic [31:0] MAX_STAT = 32'hFFFFFFFF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pixels around one even-row position: current rows y-2..y+3,
  // previous rows y-1..y+2
  typedef struct packed {
    logic [7:0] c_m2;
    logic [7:0] c_m1;
    logic [7:0] c_0;
    logic [7:0] c_1;
    logic [7:0] c_2;
    logic [7:0] c_3;
    logic [7:0] p_m1;
    logic [7:0] p_0;
    logic [7:0] p_1;
    logic [7:0] p_2;
  } pix_type;

  // one statistic word toward the frame summing unit
  typedef struct packed {
    logic        valid;
    logic        stream;
    logic [3:0]  index;
    logic [31:0] data;
  } stat_type;

  typedef enum logic [1:0] {PHASE_ACCUM, PHASE_FINAL, PHASE_WRITE}
    phase_type;
endpackage : fms_pkg

/* rtl/field_motion_statistics.sv */
// field motion statistics: per-pixel differences, tears, frame sums
`timescale 1ns/1ns
module field_motion_statistics (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pix_valid,
  input  wire fms_pkg::pix_type  pix,
  input  wire logic [3:0]        pix_col,
  input  wire logic              pix_row,
  output logic                   pix_ready,
  input  wire logic              frame_start,
  input  wire logic              frame_end,
  output fms_pkg::stat_type      stat_out,
  output logic                   bottom_first,
  output logic                   prev_read_enable,
  output logic                   interlaced_assumed
);

  // complete state of the block
  typedef struct packed {
    fms_pkg::phase_type phase;          // block processing phase
    logic               stream_sel;     // selected accumulator set
    logic               bottom_first;   // field order
    logic               first_frame;    // first frame of a sequence
    logic               prev_read_en;   // previous frame fetch allowed
    logic               interlaced;     // cadence assumes interlaced
    logic [15:0]        move_thr;       // moving pixel threshold
    logic [9:0]         vsmooth_thr;    // vertical smooth threshold
    logic [15:0]        tear_min;       // tear minimum difference
    logic [15:0]        tear_floor;     // tear count floor
    logic               aw_held;        // write address captured
    logic [7:0]         awaddr;
    logic               w_held;         // write data captured
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               pix_ready;
    logic [4:0][20:0]   blk_sum;        // block difference sums
    logic [2:0][5:0]    blk_cnt;        // block counters five to seven
    logic [2:0][31:0]   tear;           // raw tear flags per position
    logic [1:0][10:0][31:0] acc;        // frame sums per stream
    logic               end_pending;    // frame end awaiting write-out
    logic [3:0]         wr_idx;         // next statistic to emit
    fms_pkg::stat_type  stat;
    logic [15:0]        frames_done;    // completed frame count
  } state_type;

  state_type s;       // registered state
  state_type next_s;  // next state

  // squared difference of two pixels
  function automatic logic [15:0] sq(input logic [7:0] a,
                                     input logic [7:0] b);
    logic [8:0] d;
    d = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
    sq = 16'(d * d);
  endfunction : sq

  // vertical smoothness term around a center sample
  function automatic logic signed [11:0] smooth(input logic [7:0] up,
                                                input logic [7:0] mid,
                                                input logic [7:0] dn);
    logic [8:0] a;
    logic [8:0] b;
    a = (mid >= up) ? {1'b0, mid - up} : {1'b0, up - mid};
    b = (mid >= dn) ? {1'b0, mid - dn} : {1'b0, dn - mid};
    smooth = $signed({3'h0, a}) + $signed({3'h0, b})
           - $signed({3'h0, 9'(up) + 9'(dn)});
  endfunction : smooth

  // number of set bits in a tear map
  function automatic logic [5:0] count(input logic [31:0] v);
    count = 6'h0;
    for (int i = 0; i < fms_pkg::BLK_PIX; i++)
      count = count + 6'(v[i]);
  endfunction : count

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[8*i +: 8] = nw[8*i +: 8];
  endfunction : merge

  // surviving tears: a flag stays when a neighbour carries it too
  logic [2:0][31:0] survive;  // tear flags after stray removal
  genvar gn, gi;
  generate
    for (gn = 0; gn < 3; gn++) begin : g_flag
      for (gi = 0; gi < fms_pkg::BLK_PIX; gi++) begin : g_pos
        localparam int COL = gi % fms_pkg::BLK_COLS;
        localparam int OTH = (gi + fms_pkg::BLK_COLS) % fms_pkg::BLK_PIX;
        localparam int LFT = (COL > 0) ? gi - 1 : gi;
        localparam int RGT = (COL < fms_pkg::BLK_COLS - 1) ? gi + 1 : gi;
        // block edges see no neighbour beyond the block
        assign survive[gn][gi] = s.tear[gn][gi] & (
          ((COL > 0) & s.tear[gn][LFT]) |
          ((COL < fms_pkg::BLK_COLS - 1) & s.tear[gn][RGT]) |
          s.tear[gn][OTH]);
      end
    end
  endgenerate

  // next-state logic
  always_comb
  begin
    logic [15:0]        d_tt;     // current/previous top
    logic [15:0]        d_bb;     // current/previous bottom
    logic [15:0]        d_tb;     // current top/bottom
    logic [15:0]        d_tpb;    // current top/previous bottom
    logic [15:0]        d_bpt;    // current bottom/previous top
    logic [15:0]        d_ctct;   // same-field current top
    logic [15:0]        d_cbcb;   // same-field current bottom
    logic [15:0]        d_ptpt;   // same-field previous top
    logic [15:0]        d_pbpb;   // same-field previous bottom
    logic signed [11:0] sm_t;     // smoothness, current top
    logic signed [11:0] sm_b;     // smoothness, current bottom
    logic               moving;
    logic               vsmooth;
    logic [4:0]         pos;
    logic [31:0]        v7;
    logic [31:0]        v8;
    logic [31:0]        v9;
    logic [31:0]        v10;
    logic               wr_fire;
    logic               wr_ok;
    logic [31:0]        ctrl_word;
    d_tt    = sq(pix.c_0, pix.p_0);
    d_bb    = sq(pix.c_1, pix.p_1);
    d_tb    = sq(pix.c_0, pix.c_1);
    d_tpb   = sq(pix.c_0, pix.p_1);
    d_bpt   = sq(pix.c_1, pix.p_0);
    d_ctct  = sq(pix.c_0, pix.c_2);
    d_cbcb  = sq(pix.c_m1, pix.c_1);
    d_ptpt  = sq(pix.p_0, pix.p_2);
    d_pbpb  = sq(pix.p_m1, pix.p_1);
    sm_t    = smooth(pix.c_m2, pix.c_0, pix.c_2);
    sm_b    = smooth(pix.c_m1, pix.c_1, pix.c_3);
    moving  = (17'(d_tt) + 17'(d_bb)) > 17'(s.move_thr);
    vsmooth = (sm_t < $signed({2'h0, s.vsmooth_thr})) &&
              (sm_b < $signed({2'h0, s.vsmooth_thr}));
    pos     = {pix_row, pix_col};
    v7      = 32'(s.blk_cnt[2]);
    v8      = 32'(count(survive[0]));
    v9      = 32'(count(survive[1]));
    v10     = 32'(count(survive[2]));
    wr_fire = 1'b0;
    wr_ok   = 1'b1;
    ctrl_word = {29'h0, s.first_frame, s.bottom_first, s.stream_sel};
    next_s  = s;
    next_s.stat.valid = 1'b0;

    // ---- bus write: address and data taken in either order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      wr_fire = 1'b1;
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // register update on a completed write
    if (wr_fire)
    begin
      unique case (s.awaddr)
        fms_pkg::OFS_CTRL:
        begin
          ctrl_word = merge(ctrl_word, s.wdata, s.wstrb);
          next_s.stream_sel   = ctrl_word[fms_pkg::CTRL_STREAM];
          next_s.bottom_first = ctrl_word[fms_pkg::CTRL_BOTTOM_FIRST];
          next_s.first_frame  = ctrl_word[fms_pkg::CTRL_FIRST_FRAME];
        end
        fms_pkg::OFS_MOVE_THR:
          next_s.move_thr = 16'(merge(32'(s.move_thr), s.wdata, s.wstrb));
        fms_pkg::OFS_VSMOOTH:
          next_s.vsmooth_thr =
            10'(merge(32'(s.vsmooth_thr), s.wdata, s.wstrb));
        fms_pkg::OFS_TEAR_MIN:
          next_s.tear_min = 16'(merge(32'(s.tear_min), s.wdata, s.wstrb));
        fms_pkg::OFS_TEAR_FLOOR:
          next_s.tear_floor =
            16'(merge(32'(s.tear_floor), s.wdata, s.wstrb));
        default:
          wr_ok = 1'b0;  // unmapped or read-only
      endcase
      next_s.bresp = wr_ok ? fms_pkg::RESP_OKAY : fms_pkg::RESP_SLVERR;
    end
    next_s.bottom_first = next_s.bottom_first;
    next_s.prev_read_en = !next_s.first_frame;
    next_s.interlaced   = next_s.first_frame;

    // ---- bus read: one cycle from address to data
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = fms_pkg::RESP_OKAY;
      if (s_axi_araddr >= fms_pkg::OFS_RESULT &&
          s_axi_araddr < fms_pkg::OFS_RESULT + 8'(4 * fms_pkg::NUM_VAR) &&
          s_axi_araddr[1:0] == 2'h0)
        next_s.rdata = s.acc[s.stream_sel]
                         [4'((s_axi_araddr - fms_pkg::OFS_RESULT) >> 2)];
      else
        unique case (s_axi_araddr)
          fms_pkg::OFS_CTRL:       next_s.rdata = ctrl_word;
          fms_pkg::OFS_MOVE_THR:   next_s.rdata = 32'(s.move_thr);
          fms_pkg::OFS_VSMOOTH:    next_s.rdata = 32'(s.vsmooth_thr);
          fms_pkg::OFS_TEAR_MIN:   next_s.rdata = 32'(s.tear_min);
          fms_pkg::OFS_TEAR_FLOOR: next_s.rdata = 32'(s.tear_floor);
          fms_pkg::OFS_STATUS:
            next_s.rdata = {s.frames_done, 13'h0, s.end_pending,
                            2'(s.phase)};
          default:
          begin
            next_s.rdata = 32'h0;
            next_s.rresp = fms_pkg::RESP_SLVERR;
          end
        endcase
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    next_s.arready = !next_s.rvalid;

    // ---- frame control
    if (frame_start)
      next_s.acc[s.stream_sel] = '0;
    if (frame_end)
      next_s.end_pending = 1'b1;

    // ---- block processing
    unique case (s.phase)
      fms_pkg::PHASE_ACCUM:
      begin
        if (pix_valid && s.pix_ready)
        begin
          next_s.blk_sum[0] = s.blk_sum[0] + 21'(d_tt);
          next_s.blk_sum[1] = s.blk_sum[1] + 21'(d_bb);
          next_s.blk_sum[2] = s.blk_sum[2] + 21'(d_tb);
          next_s.blk_sum[3] = s.blk_sum[3] + 21'(d_tpb);
          next_s.blk_sum[4] = s.blk_sum[4] + 21'(d_bpt);
          if (moving)
          begin
            if (17'(d_tb) > 17'(d_ctct) + 17'(d_cbcb))
              next_s.blk_cnt[0] = s.blk_cnt[0] + 6'h1;
            else
              next_s.blk_cnt[1] = s.blk_cnt[1] + 6'h1;
            if (vsmooth)
            begin
              next_s.blk_cnt[2] = s.blk_cnt[2] + 6'h1;
              next_s.tear[0][pos] = d_tb >= s.tear_min &&
                17'(d_tb) > 17'(d_ctct) + 17'(d_cbcb);
              next_s.tear[1][pos] = d_tpb >= s.tear_min &&
                17'(d_tpb) > 17'(d_ctct) + 17'(d_pbpb);
              next_s.tear[2][pos] = d_bpt >= s.tear_min &&
                17'(d_bpt) > 17'(d_ptpt) + 17'(d_cbcb);
            end
          end
          if (pos == 5'(fms_pkg::BLK_PIX - 1))
            next_s.phase = fms_pkg::PHASE_FINAL;
        end
        else if (s.end_pending)
        begin
          next_s.phase  = fms_pkg::PHASE_WRITE;
          next_s.wr_idx = 4'h0;
        end
      end
      fms_pkg::PHASE_FINAL:
      begin
        // dominant first tear count voids the block's 2-2 counts
        if (v8 > v9 && v8 > v10)
        begin
          v7  = 32'h0;
          v8  = 32'h0;
          v9  = 32'h0;
          v10 = 32'h0;
        end
        if (v8 < 32'(s.tear_floor))
          v8 = 32'h0;
        if (v9 < 32'(s.tear_floor))
          v9 = 32'h0;
        if (v10 < 32'(s.tear_floor))
          v10 = 32'h0;
        for (int k = 0; k < fms_pkg::NUM_DIFF; k++)
          next_s.acc[s.stream_sel][k] = next_s.acc[s.stream_sel][k] +
            32'(s.blk_sum[k] >> fms_pkg::DIV_SHIFT);
        next_s.acc[s.stream_sel][5] = next_s.acc[s.stream_sel][5] +
          32'(s.blk_cnt[0]);
        next_s.acc[s.stream_sel][6] = next_s.acc[s.stream_sel][6] +
          32'(s.blk_cnt[1]);
        next_s.acc[s.stream_sel][7] = next_s.acc[s.stream_sel][7] + v7;
        next_s.acc[s.stream_sel][8] = next_s.acc[s.stream_sel][8] + v8;
        next_s.acc[s.stream_sel][9] = next_s.acc[s.stream_sel][9] + v9;
        next_s.acc[s.stream_sel][10] =
          next_s.acc[s.stream_sel][10] + v10;
        next_s.blk_sum = '0;
        next_s.blk_cnt = '0;
        next_s.tear    = '0;
        next_s.phase   = fms_pkg::PHASE_ACCUM;
      end
      fms_pkg::PHASE_WRITE:
      begin
        // one statistic per cycle toward the summing unit
        next_s.stat.valid  = 1'b1;
        next_s.stat.stream = s.stream_sel;
        next_s.stat.index  = s.wr_idx;
        if (s.first_frame && s.wr_idx != 4'h2)
          next_s.stat.data = fms_pkg::MAX_STAT;
        else
          next_s.stat.data = s.acc[s.stream_sel][s.wr_idx];
        next_s.wr_idx = s.wr_idx + 4'h1;
        if (s.wr_idx == fms_pkg::LAST_VAR)
        begin
          next_s.phase       = fms_pkg::PHASE_ACCUM;
          next_s.end_pending = frame_end;
          next_s.frames_done = s.frames_done + 16'h1;
        end
      end
    endcase
    // pixels wait until the last statistic word has left
    next_s.pix_ready = next_s.phase == fms_pkg::PHASE_ACCUM &&
                       !next_s.end_pending && !next_s.stat.valid;
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s             <= '0;
      s.phase       <= fms_pkg::PHASE_ACCUM;
      s.move_thr    <= fms_pkg::RST_MOVE_THR;
      s.vsmooth_thr <= fms_pkg::RST_VSMOOTH;
      s.tear_min    <= fms_pkg::RST_TEAR_MIN;
      s.tear_floor  <= fms_pkg::RST_TEAR_FLOOR;
      s.prev_read_en <= 1'b1;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_arready      = s.arready;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rvalid       = s.rvalid;
  assign pix_ready          = s.pix_ready;
  assign stat_out           = s.stat;
  assign bottom_first       = s.bottom_first;
  assign prev_read_enable   = s.prev_read_en;
  assign interlaced_assumed = s.interlaced;

endmodule : field_motion_statistics

/* tb/fms_props.sv */
// port assertions of the field motion statistics block
`timescale 1ns/1ns
module fms_props (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              pix_valid,
  input wire logic [3:0]        pix_col,
  input wire logic              pix_row,
  input wire logic              pix_ready,
  input wire logic              frame_end,
  input wire fms_pkg::stat_type stat_out,
  input wire logic              prev_read_enable,
  input wire logic              interlaced_assumed
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // words leave in index order, back to back
  AST_WORD_ORDER:
    assert property (stat_out.valid && stat_out.index != fms_pkg::LAST_VAR
      |=> stat_out.valid && stat_out.index == $past(stat_out.index) + 4'h1)
    else $error("word order broken");
  AST_WORD_LAST:
    assert property (stat_out.valid && stat_out.index == fms_pkg::LAST_VAR
      |=> !stat_out.valid) else $error("burst longer than eleven");
  AST_END_TO_WORDS:
    assert property (frame_end && pix_ready
      |-> ##[1:4] (stat_out.valid && stat_out.index == 4'h0))
    else $error("no write-out after frame end");
  AST_BLOCK_CLOSE:
    assert property (pix_valid && pix_ready && pix_row && pix_col == 4'hF
      |=> !pix_ready ##1 pix_ready) else $error("block close timing");
  AST_FIRST_FLAGS:
    assert property (interlaced_assumed == !prev_read_enable)
    else $error("first frame flags disagree");
  AST_FIRST_MAX:
    assert property (stat_out.valid && interlaced_assumed
      && stat_out.index != 4'h2 |-> stat_out.data == fms_pkg::MAX_STAT)
    else $error("first frame word not maximum");
  AST_NO_PIX_IN_WRITE:
    assert property (stat_out.valid |-> !pix_ready)
    else $error("pixels accepted during write-out");
  AST_TEARS_LE_SMOOTH:
    assert property (stat_out.valid && stat_out.index == 4'h8
      && !interlaced_assumed |-> stat_out.data <= $past(stat_out.data))
    else $error("tear count above smooth count");
endmodule : fms_props
bind field_motion_statistics fms_props u_fms_props (.*);

/* tb/fms_partner.sv */
// pixel pipeline and frame summing unit model
`timescale 1ns/1ns
module fms_partner (
  input  wire logic              aclk,
  input  wire logic              pix_ready,
  input  wire fms_pkg::stat_type stat_out,
  output fms_pkg::pix_type       pix,
  output logic                   pix_valid,
  output logic [3:0]             pix_col,
  output logic                   pix_row,
  output logic                   frame_start,
  output logic                   frame_end
);
  logic [31:0] res [0:15];  // collected words by index
  logic        stm;         // stream tag of last word
  int          nw;          // words seen this frame
  initial
  begin
    {pix, pix_valid, pix_col, pix_row, frame_start, frame_end} = '0;
    nw = 0;
  end
  // summing unit side: no backpressure, take every word
  always @(posedge aclk)
    if (stat_out.valid === 1'b1)
    begin
      res[stat_out.index] <= stat_out.data;
      stm <= stat_out.stream;
      nw <= nw + 1;
    end
  // one frame of blocks, closing position sent last; with lone >= 0
  // only that block position carries v, the others are flat zero
  task automatic run_frame(input fms_pkg::pix_type v, input int nblk,
                           input int lone = -1);
    @(posedge aclk);
    frame_start <= 1'b1;
    nw = 0;
    @(posedge aclk);
    frame_start <= 1'b0;
    for (int i = 0; i < nblk * 32; i++)
    begin
      pix <= (lone < 0 || i % 32 == lone) ? v : 80'h0;
      pix_col <= i[3:0];
      pix_row <= i[4];
      pix_valid <= 1'b1;
      do @(negedge aclk); while (pix_ready !== 1'b1);
      @(posedge aclk);
    end
    pix_valid <= 1'b0;
    pix <= ~v;  // released bus shows no stale pixel
    do @(negedge aclk); while (pix_ready !== 1'b1);
    @(posedge aclk);
    frame_end <= 1'b1;
    @(posedge aclk);
    frame_end <= 1'b0;
    while (nw < 11) @(posedge aclk);
  endtask : run_frame
endmodule : fms_partner

/* tb/field_motion_statistics_tb.sv */
// self-checking bench of the field motion statistics block
`timescale 1ns/1ns
module field_motion_statistics_tb;
  typedef logic [31:0] words_type [0:10];
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pix_valid, pix_row, pix_ready, frame_start;
  logic frame_end, bottom_first, prev_read_enable, interlaced_assumed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] pix_col;
  fms_pkg::pix_type pix;
  fms_pkg::stat_type stat_out;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  // a: top 40 bottom 0, prev top 10 bottom 20; b: prev swapped fields
  fms_pkg::pix_type pat_a = 80'h2800_2800_2800_140A_140A;
  fms_pkg::pix_type pat_b = 80'h2800_2800_2800_2800_2800;
  // 32 positions: sums 2*d*d, counters 32 or 0
  words_type blk_a = '{1800, 800, 3200, 800, 200, 32, 0, 32, 32, 32, 32};
  words_type blk_b = '{3200, 3200, 3200, 0, 0, 32, 0, 0, 0, 0, 0};
  words_type blk;
  field_motion_statistics u_field_motion_statistics (.*);
  fms_partner u_fms_partner (.*);
  always #4 aclk = ~aclk;
  // hang guard
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (s_axi_awready !== 1'b1);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (s_axi_wready !== 1'b1);
        @(posedge aclk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  // one frame, all eleven words and the stream tag judged
  task automatic frame(input fms_pkg::pix_type v, input int n,
                       input words_type e, input logic s,
                       input int lone = -1);
    u_fms_partner.run_frame(v, n, lone);
    for (int i = 0; i < 11; i++)
      chk($sformatf("word %0d", i), u_fms_partner.res[i], e[i] * n);
    chk("stream", {31'h0, u_fms_partner.stm}, {31'h0, s});
  endtask : frame
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(fms_pkg::OFS_MOVE_THR, 32'h100, 0);
    rd(fms_pkg::OFS_VSMOOTH, 32'h40, 0);
    rd(fms_pkg::OFS_TEAR_MIN, 32'h40, 0);
    rd(fms_pkg::OFS_TEAR_FLOOR, 32'h4, 0);
    rd(8'h3C, 32'h0, 2);
    wr(fms_pkg::OFS_RESULT, 32'h1, 2);
    wr(fms_pkg::OFS_CTRL, 32'h0, 0);
    frame(pat_a, 2, blk_a, 1'b0);
    frame(pat_a, 1, blk_a, 1'b0);
    wr(fms_pkg::OFS_CTRL, 32'h1, 0);
    frame(pat_b, 1, blk_b, 1'b1);
    rd(fms_pkg::OFS_RESULT, 32'd3200, 0);
    wr(fms_pkg::OFS_CTRL, 32'h0, 0);
    rd(fms_pkg::OFS_RESULT, 32'd1800, 0);
    // one isolated tear position: its tears are strays and vanish
    blk = '{56, 25, 100, 25, 6, 1, 0, 1, 0, 0, 0};
    frame(pat_a, 1, blk, 1'b0, 5);
    wr(fms_pkg::OFS_TEAR_FLOOR, 32'd33, 0);
    blk = blk_a;
    blk[8] = 0;
    blk[9] = 0;
    blk[10] = 0;
    frame(pat_a, 1, blk, 1'b0);
    wr(fms_pkg::OFS_CTRL, 32'h6, 0);
    chk("order", {31'h0, bottom_first}, 32'h1);
    chk("prev read", {31'h0, prev_read_enable}, 32'h0);
    chk("interlaced", {31'h0, interlaced_assumed}, 32'h1);
    blk = '{default: 32'hFFFFFFFF};
    blk[2] = 3200;
    frame(pat_a, 1, blk, 1'b0);
    results();
  end
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
endmodule : field_motion_statistics_tb
